/* File: tpl_defines.svh */
// Offsets, field positions, reset values, widths and timing counts of the policer.
`ifndef TPL_DEFINES_SVH
`define TPL_DEFINES_SVH

// ==========================================================================
// Widths
`define TPL_CNT_W 24
`define TPL_LEN_W 16
`define TPL_RATE_W 16

// ==========================================================================
// Timing
`define TPL_CLK_PERIOD_NS 25
`define TPL_REFILL_NS 1000
`define TPL_REFILL_CYC ((`TPL_REFILL_NS) / (`TPL_CLK_PERIOD_NS))

// ==========================================================================
// Register byte offsets
`define TPL_OFS_CTRL 6'h00
`define TPL_OFS_CRATE 6'h04
`define TPL_OFS_PRATE 6'h08
`define TPL_OFS_CSIZE 6'h0C
`define TPL_OFS_XSIZE 6'h10
`define TPL_OFS_CCOUNT 6'h14
`define TPL_OFS_XCOUNT 6'h18
`define TPL_OFS_NGREEN 6'h1C
`define TPL_OFS_NYELLOW 6'h20
`define TPL_OFS_NRED 6'h24

// ==========================================================================
// Control fields
`define TPL_CTRL_EN 0
`define TPL_CTRL_MODE 1
`define TPL_CTRL_FILL 2

// ==========================================================================
// Reset values
`define TPL_RST_EN 1'h0
`define TPL_RST_MODE 1'h0
`define TPL_RST_CRATE 16'h0010
`define TPL_RST_PRATE 16'h0020
`define TPL_RST_CSIZE 24'h000800
`define TPL_RST_XSIZE 24'h001000

`endif

/* File: tpl_pkg.sv */
// Types shared by the policer modules.
`include "tpl_defines.svh"

package tpl_pkg;

	// ==========================================================================
	// Types
	typedef enum logic [1:0] {
		TPL_GREEN = 2'h0,
		TPL_YELLOW = 2'h1,
		TPL_RED = 2'h2
	} tpl_color_e;

	typedef enum logic {
		TPL_SINGLE = 1'h0,
		TPL_TWO = 1'h1
	} tpl_mode_e;

	typedef logic [`TPL_CNT_W-1:0] tpl_cnt_t;
	typedef logic [`TPL_LEN_W-1:0] tpl_len_t;
	typedef logic [`TPL_RATE_W-1:0] tpl_rate_t;

endpackage

/* File: tpl_bucket_if.sv */
// Signals between the policer core and one token bucket.
`timescale 1ns/100ps

interface tpl_bucket_if;
	import tpl_pkg::*;
	tpl_cnt_t addTok;
	tpl_cnt_t takeTok;
	tpl_cnt_t limit;
	logic load;
	tpl_cnt_t count;
	tpl_cnt_t spill;

	modport store (input addTok, input takeTok, input limit, input load,
		output count, output spill);
	modport user (output addTok, output takeTok, output limit, output load,
		input count, input spill);
endinterface

/* File: tpl_rate.sv */
// Refill generator: emits a rate's worth of tokens once per refill interval.
`timescale 1ns/100ps
`include "tpl_defines.svh"

module tpl_rate (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Rate and tokens
	input wire tpl_pkg::tpl_rate_t rate,
	output tpl_pkg::tpl_cnt_t tokens
);
	import tpl_pkg::*;

	localparam logic [7:0] LAST = 8'(`TPL_REFILL_CYC - 1);

	logic [7:0] div_q;
	tpl_cnt_t tok_q;
	wire tick = (div_q == LAST);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_q <= 8'h00;
			tok_q <= '0;
		end else if (clkEn) begin
			div_q <= tick ? 8'h00 : div_q + 8'h01;
			tok_q <= tick ? tpl_cnt_t'(rate) : '0;
		end
	end

	assign tokens = tok_q;
endmodule // tpl_rate

/* File: tpl_bucket.sv */
// One token bucket: refill, deduction, saturation and overflow spill.
`timescale 1ns/100ps
`include "tpl_defines.svh"

module tpl_bucket (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Bucket
	tpl_bucket_if.store bkt
);
	import tpl_pkg::*;

	tpl_cnt_t count_q;
	tpl_cnt_t count_d;
	logic [`TPL_CNT_W:0] sum;
	logic over;
	logic [`TPL_CNT_W:0] excess;

	// Deductions never exceed the count, so the sum cannot go negative.
	assign sum = {1'b0, count_q} + {1'b0, bkt.addTok} - {1'b0, bkt.takeTok};
	assign over = sum > {1'b0, bkt.limit};
	assign count_d = (bkt.load || over) ? bkt.limit : sum[`TPL_CNT_W-1:0]; // see R14
	// Only freshly added tokens spill; a count cut by a smaller size is
	// clamped, never moved into the other bucket.
	assign excess = sum - {1'b0, bkt.limit};
	assign bkt.spill = (over && !bkt.load) ? ((excess > {1'b0, bkt.addTok}) ?
		bkt.addTok : tpl_cnt_t'(excess)) : '0; // see R3
	assign bkt.count = count_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			count_q <= '0;
		end else if (clkEn) begin
			count_q <= count_d;
		end
	end
endmodule // tpl_bucket

/* File: tpl_policer.sv */
// Three-colour token-bucket policer with its Avalon-MM register slave.
// ==========================================================================
// Operation
// R1: Single-rate uses one rate, two buckets.
// R2: Each packet gets green, yellow or red.
// R3: Committed rate fills first; overflow fills excess.
// R4: Single-rate: enough committed tokens means green.
// R5: Green packet removes its length from committed.
// R6: Otherwise yellow if excess suffices, else red.
// R7: Dropped packets leave every bucket untouched.
// R8: Software keeps peak rate not below committed.
// R9: Two-rate refills committed and peak separately.
// R10: Two-rate: short peak bucket means red.
// R11: Peak passes: committed decides green or yellow.
// R12: One token equals one byte.
// R13: Yellow and two-rate green deduct as described.
// R14: Buckets saturate at their configured sizes.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "tpl_defines.svh"

module tpl_policer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Avalon-MM register slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Packet from the upstream path
	input wire logic pktValid,
	input wire tpl_pkg::tpl_len_t pktLen,
	output logic pktReady,
	// Colour to the downstream queue logic
	output logic colorValid,
	output tpl_pkg::tpl_color_e color,
	output tpl_pkg::tpl_len_t colorLen
);
	import tpl_pkg::*;

	// ==========================================================================
	// Register state
	logic en_q;
	tpl_mode_e mode_q;
	logic fill_q;
	tpl_rate_t cRate_q;
	tpl_rate_t pRate_q;
	tpl_cnt_t cSize_q;
	tpl_cnt_t xSize_q;
	logic [31:0] nGreen_q;
	logic [31:0] nYellow_q;
	logic [31:0] nRed_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdMux;

	// Outputs of the colour stage.
	logic cv_q;
	tpl_color_e col_q;
	tpl_len_t clen_q;

	// ==========================================================================
	// Buckets and refill
	tpl_bucket_if cBkt ();
	tpl_bucket_if xBkt ();
	tpl_cnt_t cTokens;
	tpl_cnt_t pTokens;

	tpl_rate u_crate (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.rate(cRate_q),
		.tokens(cTokens)
	);

	// Only two-rate mode consumes the peak refill; R8 is left to software.
	tpl_rate u_prate (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.rate(pRate_q),
		.tokens(pTokens)
	);

	tpl_bucket u_cbkt (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.bkt(cBkt.store)
	);

	tpl_bucket u_xbkt (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.bkt(xBkt.store)
	);

	// ==========================================================================
	// Bus decode
	wire busReq = avs_read || avs_write;
	wire wrTake = avs_write && ack_q;
	wire rdTake = avs_read && !ack_q;
	wire selCtrl = (avs_address == `TPL_OFS_CTRL);
	wire selCRate = (avs_address == `TPL_OFS_CRATE);
	wire selPRate = (avs_address == `TPL_OFS_PRATE);
	wire selCSize = (avs_address == `TPL_OFS_CSIZE);
	wire selXSize = (avs_address == `TPL_OFS_XSIZE);
	wire selNGreen = (avs_address == `TPL_OFS_NGREEN);
	wire selNYellow = (avs_address == `TPL_OFS_NYELLOW);
	wire selNRed = (avs_address == `TPL_OFS_NRED);
	wire selCCount = (avs_address == `TPL_OFS_CCOUNT);
	wire selXCount = (avs_address == `TPL_OFS_XCOUNT);
	wire wrCtrl = wrTake && selCtrl;
	wire wrCRate = wrTake && selCRate;
	wire wrPRate = wrTake && selPRate;
	wire wrCSize = wrTake && selCSize;
	wire wrXSize = wrTake && selXSize;
	wire clrGreen = wrTake && selNGreen;
	wire clrYellow = wrTake && selNYellow;
	wire clrRed = wrTake && selNRed;
	wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Merges the enabled byte lanes of the write data into an old value.
	function automatic logic [31:0] merge(input logic [31:0] old);
		merge = (old & ~beMask) | (avs_writedata & beMask);
	endfunction

	wire [31:0] ctrlNew = merge({29'h0, fill_q, mode_q, en_q});
	wire [31:0] cRateNew = merge({16'h0, cRate_q});
	wire [31:0] pRateNew = merge({16'h0, pRate_q});
	wire [31:0] cSizeNew = merge({8'h0, cSize_q});
	wire [31:0] xSizeNew = merge({8'h0, xSize_q});

	// Every request answers one cycle after it is raised; the extra cycle lets
	// read data come from a flip-flop rather than the decode tree.
	assign avs_waitrequest = busReq && !ack_q;
	assign avs_readdata = rdata_q;

	always_comb begin
		if (selCtrl) begin
			rdMux = {29'h0, 1'b0, mode_q, en_q};
		end else if (selCRate) begin
			rdMux = {16'h0, cRate_q};
		end else if (selPRate) begin
			rdMux = {16'h0, pRate_q};
		end else if (selCSize) begin
			rdMux = {8'h0, cSize_q};
		end else if (selXSize) begin
			rdMux = {8'h0, xSize_q};
		end else if (selCCount) begin
			rdMux = {8'h0, cBkt.count};
		end else if (selXCount) begin
			rdMux = {8'h0, xBkt.count};
		end else if (selNGreen) begin
			rdMux = nGreen_q;
		end else if (selNYellow) begin
			rdMux = nYellow_q;
		end else if (selNRed) begin
			rdMux = nRed_q;
		end else begin
			rdMux = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else if (clkEn) begin
			ack_q <= busReq && !ack_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else if (clkEn && rdTake) begin
			rdata_q <= rdMux;
		end
	end

	// ==========================================================================
	// Configuration registers
	// The fill bit is a one-cycle pulse, so a later control write that leaves
	// it set reloads the buckets again only because software asked for it.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fill_q <= 1'b0;
		end else if (clkEn) begin
			fill_q <= wrCtrl && ctrlNew[`TPL_CTRL_FILL];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			en_q <= `TPL_RST_EN;
			mode_q <= tpl_mode_e'(`TPL_RST_MODE);
		end else if (clkEn && wrCtrl) begin
			en_q <= ctrlNew[`TPL_CTRL_EN];
			mode_q <= tpl_mode_e'(ctrlNew[`TPL_CTRL_MODE]);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cRate_q <= `TPL_RST_CRATE;
		end else if (clkEn && wrCRate) begin
			cRate_q <= cRateNew[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pRate_q <= `TPL_RST_PRATE;
		end else if (clkEn && wrPRate) begin
			pRate_q <= pRateNew[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cSize_q <= `TPL_RST_CSIZE;
		end else if (clkEn && wrCSize) begin
			cSize_q <= cSizeNew[23:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			xSize_q <= `TPL_RST_XSIZE;
		end else if (clkEn && wrXSize) begin
			xSize_q <= xSizeNew[23:0];
		end
	end

	// ==========================================================================
	// Colour decision
	// Lengths are bytes and tokens are bytes, so they compare directly.
	wire tpl_cnt_t lenTok = tpl_cnt_t'(pktLen); // see R12
	wire cOk = cBkt.count >= lenTok;
	wire xOk = xBkt.count >= lenTok;
	wire twoRate = (mode_q == TPL_TWO);
	wire pktTake = pktValid && pktReady;
	tpl_color_e decide;

	// Packets wait while the policer is disabled so none pass uncoloured.
	assign pktReady = en_q && !fill_q;

	always_comb begin
		if (twoRate) begin
			if (!xOk) begin
				decide = TPL_RED; // see R10
			end else if (cOk) begin
				decide = TPL_GREEN; // see R11
			end else begin
				decide = TPL_YELLOW; // see R11
			end
		end else begin
			if (cOk) begin
				decide = TPL_GREEN; // see R4 R1
			end else if (xOk) begin
				decide = TPL_YELLOW; // see R6
			end else begin
				decide = TPL_RED; // see R6
			end
		end
	end

	wire isGreen = pktTake && (decide == TPL_GREEN);
	wire isYellow = pktTake && (decide == TPL_YELLOW);
	wire isRed = pktTake && (decide == TPL_RED);

	// ==========================================================================
	// Bucket steering
	// Red packets deduct nothing because downstream drops them.
	assign cBkt.takeTok = isGreen ? lenTok : '0; // see R5 R7
	assign xBkt.takeTok = (isYellow || (isGreen && twoRate)) ?
		lenTok : '0; // see R13 R7
	assign cBkt.addTok = cTokens; // see R3 R9
	// Single-rate: excess fills only from the committed overflow.
	assign xBkt.addTok = twoRate ? pTokens : cBkt.spill; // see R3 R9
	assign cBkt.limit = cSize_q; // see R14
	assign xBkt.limit = xSize_q; // see R14
	assign cBkt.load = fill_q;
	assign xBkt.load = fill_q;

	// ==========================================================================
	// Colour output stage
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cv_q <= 1'b0;
			col_q <= TPL_GREEN;
			clen_q <= '0;
		end else if (clkEn) begin
			cv_q <= pktTake;
			if (pktTake) begin
				col_q <= decide; // see R2
				clen_q <= pktLen;
			end
		end
	end

	assign colorValid = cv_q;
	assign color = col_q;
	assign colorLen = clen_q;

	// ==========================================================================
	// Colour counters
	// A write clears a counter; a packet counted in the same cycle wins and
	// leaves the count at one so no event is lost.
	wire [31:0] nGreen_d = clrGreen ? {31'h0, isGreen} : nGreen_q + {31'h0, isGreen};
	wire [31:0] nYellow_d = clrYellow ? {31'h0, isYellow} : nYellow_q + {31'h0, isYellow};
	wire [31:0] nRed_d = clrRed ? {31'h0, isRed} : nRed_q + {31'h0, isRed};

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			nGreen_q <= 32'h0000_0000;
		end else if (clkEn) begin
			nGreen_q <= nGreen_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			nYellow_q <= 32'h0000_0000;
		end else if (clkEn) begin
			nYellow_q <= nYellow_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			nRed_q <= 32'h0000_0000;
		end else if (clkEn) begin
			nRed_q <= nRed_d;
		end
	end

endmodule // tpl_policer

/* File: tpl_policer_asserts.sv */
// Concurrent checks on the ports of the policer.
`timescale 1ns/100ps

module tpl_policer_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Register bus
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Packets and colours
	input wire logic pktValid,
	input wire tpl_pkg::tpl_len_t pktLen,
	input wire logic pktReady,
	input wire logic colorValid,
	input wire tpl_pkg::tpl_color_e color,
	input wire tpl_pkg::tpl_len_t colorLen
);
	import tpl_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic req;
	logic ctrlWr;
	logic take;
	assign req = avs_read | avs_write;
	assign ctrlWr = avs_write & ~avs_waitrequest & (avs_address == 6'h00) & avs_byteenable[0]
		& clkEn;
	assign take = pktValid & pktReady;

	// ==========================================================================
	// Register bus
	a_wait_one_cycle: assert property (req && avs_waitrequest && clkEn |=> !avs_waitrequest)
		else $error("waitrequest not released after one cycle");
	a_wait_when_idle: assert property (!req |-> !avs_waitrequest)
		else $error("waitrequest high without a request");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h24
		|-> avs_readdata == 32'h0)
		else $error("unmapped read returned nonzero data");

	// ==========================================================================
	// Packet acceptance
	a_fill_stalls_pkt: assert property (ctrlWr && avs_writedata[2] |=> !pktReady)
		else $error("packet accepted in the cycle after a fill");
	a_enable_opens: assert property (ctrlWr && avs_writedata[0] && !avs_writedata[2] |=> pktReady)
		else $error("enable did not open packet input");
	a_disable_shuts: assert property (ctrlWr && !avs_writedata[0] |=> !pktReady [*2])
		else $error("packet input open while disabled");

	// ==========================================================================
	// Colour output
	a_color_after_take: assert property (take && clkEn |=> colorValid && colorLen == $past(pktLen))
		else $error("colour missing or wrong length one cycle after take");
	a_no_spurious_color: assert property (!take && clkEn |=> !colorValid)
		else $error("colour pulse without a packet");
	a_color_legal: assert property (colorValid |-> color inside {TPL_GREEN, TPL_YELLOW, TPL_RED})
		else $error("illegal colour code");
	a_color_holds: assert property (!colorValid |-> $stable(color) && $stable(colorLen))
		else $error("colour changed without a pulse");

	c_green: cover property (colorValid && color == TPL_GREEN);
	c_yellow: cover property (colorValid && color == TPL_YELLOW);
	c_red: cover property (colorValid && color == TPL_RED);
endmodule // tpl_policer_asserts

bind tpl_policer tpl_policer_asserts i_tpl_policer_asserts (.clk(clk), .rst_b(rst_b),
	.clkEn(clkEn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pktValid(pktValid),
	.pktLen(pktLen), .pktReady(pktReady), .colorValid(colorValid), .color(color),
	.colorLen(colorLen));

/* File: tpl_pkt_model.sv */
// Upstream packet source and downstream colour sink for the policer.
`timescale 1ns/100ps

module tpl_pkt_model (
	// Clock
	input wire logic clk,
	// Packet to the policer
	output logic pktValid,
	output tpl_pkg::tpl_len_t pktLen,
	input wire logic pktReady,
	// Colour from the policer
	input wire logic colorValid,
	input wire tpl_pkg::tpl_color_e color
);
	import tpl_pkg::*;

	initial begin
		pktValid = 1'b0;
		pktLen = 16'h0;
	end

	// Lengths are byte counts, one token per byte.
	task automatic send(input tpl_len_t len, output tpl_color_e col, output logic seen);
		@(posedge clk);
		pktValid <= 1'b1;
		pktLen <= len;
		do begin
			@(posedge clk);
		end while (pktReady !== 1'b1);
		pktValid <= 1'b0;
		// A released length is inverted so a stale value can never pass for a match.
		pktLen <= ~len;
		@(negedge clk);
		seen = colorValid;
		col = color;
	endtask
endmodule // tpl_pkt_model

/* File: three_color_traffic_policer_tb.sv */
// Self-checking testbench of the policer.
`timescale 1ns/100ps
`include "tpl_defines.svh"

module three_color_traffic_policer_tb;
	import tpl_pkg::*;

	logic clk;
	logic rst_b;
	logic clkEn;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic pktValid;
	tpl_len_t pktLen;
	logic pktReady;
	logic colorValid;
	tpl_color_e color;
	tpl_len_t colorLen;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	tpl_len_t sLen[5] = '{16'h3C, 16'h3C, 16'h32, 16'h28, 16'h01};
	tpl_color_e sCol[5] = '{TPL_GREEN, TPL_RED, TPL_YELLOW, TPL_GREEN, TPL_RED};
	tpl_len_t tLen[4] = '{16'h64, 16'h28, 16'h14, 16'h0A};
	tpl_color_e tCol[4] = '{TPL_GREEN, TPL_YELLOW, TPL_RED, TPL_YELLOW};

	tpl_policer i_tpl_policer (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pktValid(pktValid),
		.pktLen(pktLen), .pktReady(pktReady), .colorValid(colorValid), .color(color),
		.colorLen(colorLen));

	tpl_pkt_model i_tpl_pkt_model (.clk(clk), .pktValid(pktValid), .pktLen(pktLen),
		.pktReady(pktReady), .colorValid(colorValid), .color(color));

	// ==========================================================================
	// Clock and timeout
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end

	// ==========================================================================
	// Tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input string name, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(name, q, exp);
	endtask

	task automatic pkt(input tpl_len_t len, input tpl_color_e exp);
		tpl_color_e c;
		logic v;
		i_tpl_pkt_model.send(len, c, v);
		check("colorValid", {31'h0, v}, 32'h1);
		check("color", {30'h0, c}, {30'h0, exp});
		check("colorLen", {16'h0, colorLen}, {16'h0, len});
	endtask

	// ==========================================================================
	// Tests
	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd("ctrl", `TPL_OFS_CTRL, 32'h0);
		rd("crate", `TPL_OFS_CRATE, 32'h10);
		rd("prate", `TPL_OFS_PRATE, 32'h20);
		rd("csize", `TPL_OFS_CSIZE, 32'h800);
		rd("xsize", `TPL_OFS_XSIZE, 32'h1000);
		rd("ccount", `TPL_OFS_CCOUNT, 32'h0);
		rd("unmapped", 6'h3C, 32'h0);
		// Zero rates keep refill out of the colour decisions below.
		wr(`TPL_OFS_CRATE, 32'h0);
		wr(`TPL_OFS_PRATE, 32'h0);
		wr(`TPL_OFS_CSIZE, 32'h64);
		wr(`TPL_OFS_XSIZE, 32'h32);
		wr(`TPL_OFS_CTRL, 32'h5);
		wr(`TPL_OFS_CCOUNT, 32'hFF);
		rd("ccount", `TPL_OFS_CCOUNT, 32'h64);
		rd("xcount", `TPL_OFS_XCOUNT, 32'h32);
		for (int i = 0; i < 5; i++) begin
			pkt(sLen[i], sCol[i]);
		end
		rd("ccount", `TPL_OFS_CCOUNT, 32'h0);
		rd("xcount", `TPL_OFS_XCOUNT, 32'h0);
		rd("ngreen", `TPL_OFS_NGREEN, 32'h2);
		rd("nyellow", `TPL_OFS_NYELLOW, 32'h1);
		rd("nred", `TPL_OFS_NRED, 32'h2);
		wr(`TPL_OFS_CRATE, 32'h1E);
		repeat (400) @(posedge clk);
		rd("ccount", `TPL_OFS_CCOUNT, 32'h64);
		rd("xcount", `TPL_OFS_XCOUNT, 32'h32);
		wr(`TPL_OFS_CRATE, 32'h0);
		wr(`TPL_OFS_XSIZE, 32'h96);
		wr(`TPL_OFS_CTRL, 32'h7);
		for (int i = 0; i < 4; i++) begin
			pkt(tLen[i], tCol[i]);
		end
		rd("ccount", `TPL_OFS_CCOUNT, 32'h0);
		rd("pcount", `TPL_OFS_XCOUNT, 32'h0);
		// Peak rate is kept above the committed rate.
		wr(`TPL_OFS_CRATE, 32'h20);
		wr(`TPL_OFS_PRATE, 32'h40);
		repeat (300) @(posedge clk);
		rd("ccount", `TPL_OFS_CCOUNT, 32'h64);
		rd("pcount", `TPL_OFS_XCOUNT, 32'h96);
		wr(`TPL_OFS_CRATE, 32'h0);
		wr(`TPL_OFS_PRATE, 32'h0);
		wr(`TPL_OFS_XSIZE, 32'h32);
		wr(`TPL_OFS_CTRL, 32'h7);
		pkt(16'h50, TPL_RED);
		rd("ccount", `TPL_OFS_CCOUNT, 32'h64);
		rd("pcount", `TPL_OFS_XCOUNT, 32'h32);
		wr(`TPL_OFS_CTRL, 32'h3);
		rd("ctrl", `TPL_OFS_CTRL, 32'h3);
		wr(`TPL_OFS_NRED, 32'h0);
		rd("nred", `TPL_OFS_NRED, 32'h0);
		wr(`TPL_OFS_CTRL, 32'h0);
		summarize();
	end
endmodule // three_color_traffic_policer_tb
